// ===== hw/dskip_core.sv
//==================================================================
// decrement-and-skip execution unit
//==================================================================
// Purpose: runs the decrement-skip-if-zero and decrement-skip-if-not-zero
//          instructions against the file register memory
// Assumes: one clock per instruction cycle; issue valid only while ready
// Notes:   status flags are not touched, so none leave this block
`include "dskip_defs.svh"

module dskip_core
   import dskip_pkg::*;
#(
   parameter int AW = 12,
   parameter int DW = 8
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // instruction issue
   input  wire logic          issue_valid,
   input  wire logic          issue_op,
   input  wire logic [7:0]    issue_f,
   input  wire logic          issue_d,
   input  wire logic          issue_a,
   input  wire logic          next_two_word,
   output logic               ready,
   // addressing context
   input  wire logic [3:0]    bank_select_register,
   input  wire logic          ext_set_en,
   input  wire logic [AW-1:0] index_base,
   // results
   output logic               done,
   output logic               skip_taken,
   output logic               no_operation,
   output logic [DW-1:0]      w_out,
   // memory load and inspect port
   input  wire logic          ld_en,
   input  wire logic          ld_we,
   input  wire logic [AW-1:0] ld_addr,
   input  wire logic [DW-1:0] ld_data,
   output logic [DW-1:0]      ld_rdata
);

   dskip_mem_if #(.AW(AW), .DW(DW)) mif ();

   dskip_state_t  state_reg;
   dskip_state_t  state_next;
   dskip_op_t     op_reg;
   logic          d_reg;
   logic          two_reg;
   logic [AW-1:0] addr_reg;
   logic [DW-1:0] w_reg;
   logic [DW-1:0] result;
   logic          skip;
   logic          issue;
   logic [AW-1:0] issue_addr;

   //==================================================================
   // address resolution
   //==================================================================
   // maps f, access bit and context to a data address
   function automatic logic [AW-1:0] resolve(input logic [7:0] f, input logic a,
                                             input logic ext, input logic [3:0] bank,
                                             input logic [AW-1:0] base);
      logic [AW-1:0] r;
      r = AW'({bank, f});
      if (!a) begin
         if (ext && (f <= `DSKIP_ACC_LIMIT)) begin
            r = base + AW'(f);
         end else if (f <= `DSKIP_ACC_LIMIT) begin
            r = AW'({`DSKIP_LOW_BANK, f});
         end else begin
            r = AW'({`DSKIP_SFR_BANK, f});
         end
      end
      return r;
   endfunction

   assign ready      = (state_reg == ST_IDLE);
   assign issue      = issue_valid && ready;
   assign issue_addr = resolve(issue_f, issue_a, ext_set_en, bank_select_register,
                               index_base);

   //==================================================================
   // datapath
   //==================================================================
   // decrement the operand read back from memory
   assign result = mif.rdata - `DSKIP_DEC_ONE;
   // skip condition per instruction
   assign skip = (op_reg == OP_SKIP_ZERO) ? (result == `DSKIP_ZERO)
                                          : (result != `DSKIP_ZERO);

   // memory port: issue reads, exec writes back when d is 1, load port when quiet
   always_comb begin
      mif.addr  = ld_addr;
      mif.we    = ld_en && ld_we && ready && !issue_valid;
      mif.wdata = ld_data;
      if (issue) begin
         mif.addr = issue_addr;
         mif.we   = 1'b0;
      end else if (state_reg == ST_EXEC) begin
         mif.addr  = addr_reg;
         mif.we    = d_reg;
         mif.wdata = result;
      end
   end

   dskip_file_mem #(.AW(AW), .DW(DW)) u_mem (
      .clk  (clk),
      .rstn (rstn),
      .port (mif.mem)
   );

   assign ld_rdata = mif.rdata;

   //==================================================================
   // instruction latch
   //==================================================================
   // hold the decoded fields for the execute cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_reg   <= OP_SKIP_ZERO;
         d_reg    <= 1'b1;
         two_reg  <= 1'b0;
         addr_reg <= '0;
      end else if (issue) begin
         op_reg   <= dskip_op_t'(issue_op);
         d_reg    <= issue_d;
         two_reg  <= next_two_word;
         addr_reg <= issue_addr;
      end
   end

   // working register takes the result when d is 0
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         w_reg <= `DSKIP_W_RST;
      end else if (state_reg == ST_EXEC && !d_reg) begin
         w_reg <= result;
      end
   end

   assign w_out = w_reg;

   //==================================================================
   // sequencer
   //==================================================================
   // exec, then one or two flush cycles on a skip
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (issue_valid) begin
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_next = skip ? ST_FLUSH1 : ST_IDLE;
         end
         ST_FLUSH1: begin
            state_next = two_reg ? ST_FLUSH2 : ST_IDLE;
         end
         ST_FLUSH2: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign done         = (state_reg == ST_EXEC);
   assign skip_taken   = done && skip;
   assign no_operation = (state_reg == ST_FLUSH1) || (state_reg == ST_FLUSH2);

   //==================================================================
   // assertions
   //==================================================================
   sequence s_flush1;
      no_operation && state_reg == ST_FLUSH1;
   endsequence

   sequence s_flush2;
      s_flush1 ##1 (no_operation && state_reg == ST_FLUSH2);
   endsequence

   // operand minus one reaches the file write or, a cycle later, the working register
   property p_dec;
      @(posedge clk) disable iff (!rstn)
         issue |=> done && (!d_reg || mif.wdata == mif.rdata - `DSKIP_DEC_ONE)
                   ##1 (d_reg || w_out == $past(mif.rdata) - `DSKIP_DEC_ONE);
   endproperty
   a_dec: assert property (p_dec) else $error("result is not operand minus one");

   property p_to_w;
      @(posedge clk) disable iff (!rstn)
         (issue && !issue_d) |=> (!mif.we ##1 w_out == $past(result));
   endproperty
   a_to_w: assert property (p_to_w) else $error("d=0 did not load w only");

   property p_to_f;
      @(posedge clk) disable iff (!rstn)
         (issue && issue_d) |=> mif.we && mif.addr == $past(issue_addr)
                                && mif.wdata == result ##1 $stable(w_out);
   endproperty
   a_to_f: assert property (p_to_f) else $error("d=1 did not write file");

   property p_sz;
      @(posedge clk) disable iff (!rstn)
         (done && op_reg == OP_SKIP_ZERO) |-> (skip_taken == (mif.rdata == `DSKIP_DEC_ONE));
   endproperty
   a_sz: assert property (p_sz) else $error("skip-if-zero decision wrong");

   property p_snz;
      @(posedge clk) disable iff (!rstn)
         (done && op_reg == OP_SKIP_NONZERO) |-> (skip_taken == (mif.rdata != `DSKIP_DEC_ONE));
   endproperty
   a_snz: assert property (p_snz) else $error("skip-if-not-zero decision wrong");

   property p_flush;
      @(posedge clk) disable iff (!rstn)
         (skip_taken && !two_reg) |=> s_flush1 ##1 ready;
   endproperty
   a_flush: assert property (p_flush) else $error("skip did not run one no_operation");

   property p_acc;
      @(posedge clk) disable iff (!rstn)
         (issue && !issue_a && !ext_set_en) |->
            mif.addr[AW-1:8] == ((issue_f <= `DSKIP_ACC_LIMIT) ? `DSKIP_LOW_BANK
                                                                : `DSKIP_SFR_BANK)
            && mif.addr[7:0] == issue_f;
   endproperty
   a_acc: assert property (p_acc) else $error("access bank address wrong");

   property p_banked;
      @(posedge clk) disable iff (!rstn)
         (issue && issue_a) |-> mif.addr == {bank_select_register, issue_f};
   endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong");

   property p_idx;
      @(posedge clk) disable iff (!rstn)
         (issue && !issue_a && ext_set_en && issue_f <= `DSKIP_ACC_LIMIT) |->
            mif.addr == index_base + AW'(issue_f);
   endproperty
   a_idx: assert property (p_idx) else $error("indexed offset address wrong");

   property p_two;
      @(posedge clk) disable iff (!rstn)
         (skip_taken && two_reg) |=> s_flush2 ##1 ready;
   endproperty
   a_two: assert property (p_two) else $error("two-word skip not three cycles");

   property p_noskip;
      @(posedge clk) disable iff (!rstn)
         (done && !skip_taken) |=> ready && !no_operation;
   endproperty
   a_noskip: assert property (p_noskip) else $error("no-skip case took extra cycles");

endmodule

// ===== hw/dskip_defs.svh
//==================================================================
// constants
//==================================================================
// Purpose: offsets, field limits, reset values for the decrement-skip unit
// Assumes: 12-bit data address, 8-bit file registers
// Notes:   definitions only
`ifndef DSKIP_DEFS_SVH
`define DSKIP_DEFS_SVH

// highest file address that maps to the low part of the access bank
`define DSKIP_ACC_LIMIT 8'h5F
// bank used for the low part of the access bank
`define DSKIP_LOW_BANK  4'h0
// bank used for the high part of the access bank
`define DSKIP_SFR_BANK  4'hF
// amount subtracted from the operand
`define DSKIP_DEC_ONE   8'h01
// zero result
`define DSKIP_ZERO      8'h00
// reset value of the working register
`define DSKIP_W_RST     8'h00
// reset value of the memory read register
`define DSKIP_RD_RST    8'h00

`endif

// ===== hw/dskip_pkg.sv
//==================================================================
// types
//==================================================================
// Purpose: shared types of the decrement-skip unit
// Assumes: one-hot state codes
// Notes:   constants live in dskip_defs.svh
package dskip_pkg;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_EXEC   = 4'b0010,
      ST_FLUSH1 = 4'b0100,
      ST_FLUSH2 = 4'b1000
   } dskip_state_t;

   // instruction select
   typedef enum logic {
      OP_SKIP_ZERO    = 1'b0,
      OP_SKIP_NONZERO = 1'b1
   } dskip_op_t;

endpackage

// ===== hw/dskip_mem_if.sv
//==================================================================
// file register port
//==================================================================
// Purpose: carries one read/write port to the file register memory
// Assumes: registered read data, write on the clock edge
// Notes:   ctrl side drives address and write, mem side returns data
interface dskip_mem_if #(
   parameter int AW = 12,
   parameter int DW = 8
);
   logic [AW-1:0] addr;
   logic          we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctrl (output addr, output we, output wdata, input rdata);
   modport mem  (input addr, input we, input wdata, output rdata);
endinterface

// ===== hw/dskip_file_mem.sv
//==================================================================
// file register memory
//==================================================================
// Purpose: data memory holding the file registers
// Assumes: single port, read data one clock after the address
// Notes:   array itself is not reset
`include "dskip_defs.svh"

module dskip_file_mem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // access port
   dskip_mem_if.mem port
);

   logic [DW-1:0] mem_reg [0:(1<<AW)-1];
   logic [DW-1:0] rdata_reg;

   // write on the edge
   always_ff @(posedge clk) begin
      if (port.we) begin
         mem_reg[port.addr] <= port.wdata;
      end
   end

   // registered read, old data on a same-cycle write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= `DSKIP_RD_RST;
      end else begin
         rdata_reg <= mem_reg[port.addr];
      end
   end

   assign port.rdata = rdata_reg;

endmodule

// ===== dv/tb_decrement_skip_instructions.sv
//==================================================================
// decrement-and-skip testbench
//==================================================================
// Purpose: self-checking bench for dskip_core
// Assumes: 10 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   file registers preloaded and inspected through the load port
module tb_decrement_skip_instructions
   import dskip_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   //==================================================================
   // signals
   //==================================================================
   logic        clk;
   logic        rstn;
   logic        issue_valid;
   logic        issue_op;
   logic [7:0]  issue_f;
   logic        issue_d;
   logic        issue_a;
   logic        next_two_word;
   logic        ready;
   logic [3:0]  bank_select_register;
   logic        ext_set_en;
   logic [11:0] index_base;
   logic        done;
   logic        skip_taken;
   logic        no_operation;
   logic [7:0]  w_out;
   logic        ld_en;
   logic        ld_we;
   logic [11:0] ld_addr;
   logic [7:0]  ld_data;
   logic [7:0]  ld_rdata;
   int          miscompares;
   int          check_count;

   // unit under test
   dskip_core #(.AW(12), .DW(8)) uut (
      .clk(clk), .rstn(rstn), .issue_valid(issue_valid), .issue_op(issue_op),
      .issue_f(issue_f), .issue_d(issue_d), .issue_a(issue_a),
      .next_two_word(next_two_word), .ready(ready),
      .bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
      .index_base(index_base), .done(done), .skip_taken(skip_taken),
      .no_operation(no_operation), .w_out(w_out), .ld_en(ld_en), .ld_we(ld_we),
      .ld_addr(ld_addr), .ld_data(ld_data), .ld_rdata(ld_rdata)
   );

   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   //==================================================================
   // shared tasks
   //==================================================================
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      check_count++;
      if (seen !== expected) begin
         miscompares++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expected);
      end
   endtask

   // verdict and end of run
   task automatic final_report();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // preload one file register
   task automatic mem_write(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk) #1;
      ld_en   = 1'b1;
      ld_we   = 1'b1;
      ld_addr = a;
      ld_data = v;
      @(posedge clk) #1;
      ld_en   = 1'b0;
      ld_we   = 1'b0;
   endtask

   // inspect one file register
   task automatic mem_read(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk) #1;
      ld_en   = 1'b1;
      ld_addr = a;
      @(posedge clk) #1;
      v     = ld_rdata;
      ld_en = 1'b0;
   endtask

   // one instruction: preload, issue, count cycles, judge destination
   task automatic run_case(input string name, input logic op, input logic [7:0] f,
                           input logic d, input logic a, input logic ext,
                           input logic [3:0] bank, input logic [11:0] base,
                           input logic two, input logic [11:0] addr,
                           input logic [7:0] init);
      logic [7:0] r;
      logic [7:0] wb;
      logic [7:0] got;
      logic       sk;
      logic       exp_sk;
      int         cyc;
      int         flushes;
      r      = init - 8'h01;
      exp_sk = (op == OP_SKIP_ZERO) ? (r == 8'h00) : (r != 8'h00);
      wb     = w_out;
      mem_write(addr, init);
      @(posedge clk) #1;
      issue_valid          = 1'b1;
      issue_op             = op;
      issue_f              = f;
      issue_d              = d;
      issue_a              = a;
      ext_set_en           = ext;
      bank_select_register = bank;
      index_base           = base;
      next_two_word        = two;
      @(posedge clk) #1;
      issue_valid = 1'b0;
      check({15'h0000, done}, 16'h0001);
      sk      = skip_taken;
      cyc     = 1;
      flushes = 0;
      while (ready !== 1'b1 && cyc < 8) begin
         @(posedge clk) #1;
         if (no_operation === 1'b1) flushes++;
         if (ready !== 1'b1) cyc++;
      end
      check({15'h0000, sk}, {15'h0000, exp_sk});
      check(cyc[15:0], exp_sk ? (two ? 16'h0003 : 16'h0002) : 16'h0001);
      check(flushes[15:0], exp_sk ? (two ? 16'h0002 : 16'h0001) : 16'h0000);
      check({8'h00, w_out}, {8'h00, d ? wb : r});
      mem_read(addr, got);
      check({8'h00, got}, {8'h00, d ? r : init});
      $display("test %s finished", name);
   endtask

   //==================================================================
   // scenarios
   //==================================================================
   // banked operand reaching zero, result written back
   task automatic t_bank_skip();
      run_case("bank_skip", OP_SKIP_ZERO, 8'h34, 1'b1, 1'b1, 1'b0, 4'h5, 12'h000, 1'b0,
               12'h534, 8'h01);
   endtask

   // low access bank, result to working register, no skip
   task automatic t_low_access_w();
      run_case("low_access_w", OP_SKIP_ZERO, 8'h10, 1'b0, 1'b0, 1'b0, 4'h7, 12'h000, 1'b0,
               12'h010, 8'h05);
   endtask

   // high access bank, non-zero variant landing on zero
   task automatic t_high_access_nz();
      run_case("high_access_nz", OP_SKIP_NONZERO, 8'hA0, 1'b1, 1'b0, 1'b0, 4'h2, 12'h000,
               1'b0, 12'hFA0, 8'h01);
   endtask

   // wrap from 00 to FF, skip over a two-word instruction
   task automatic t_wrap_two_word();
      run_case("wrap_two_word", OP_SKIP_NONZERO, 8'hFF, 1'b1, 1'b1, 1'b0, 4'hF, 12'h000,
               1'b1, 12'hFFF, 8'h00);
   endtask

   // indexed offset at the top of the low range
   task automatic t_indexed_edge();
      run_case("indexed_edge", OP_SKIP_ZERO, 8'h5F, 1'b1, 1'b0, 1'b1, 4'h3, 12'h300, 1'b1,
               12'h35F, 8'h01);
   endtask

   // extended set just above the low range stays in the access bank
   task automatic t_ext_above();
      run_case("ext_above", OP_SKIP_ZERO, 8'h60, 1'b0, 1'b0, 1'b1, 4'h3, 12'h300, 1'b0,
               12'hF60, 8'h03);
   endtask

   // reset in mid-run clears the working register and the sequencer
   task automatic t_reset_mid();
      @(posedge clk) #1;
      rstn = 1'b0;
      #1;
      check({4'h0, ready, done, skip_taken, no_operation, w_out}, 16'h0800);
      @(posedge clk) #1;
      rstn = 1'b1;
      @(posedge clk) #1;
      check({4'h0, ready, done, skip_taken, no_operation, w_out}, 16'h0800);
      $display("test %s finished", "reset_mid");
   endtask

   // extended set with access bit 1 still uses the bank register
   task automatic t_ext_banked();
      run_case("ext_banked", OP_SKIP_NONZERO, 8'h20, 1'b1, 1'b1, 1'b1, 4'hA, 12'h300, 1'b0,
               12'hA20, 8'h09);
   endtask

   //==================================================================
   // main sequence and watchdog
   //==================================================================
   initial begin
      miscompares          = 0;
      check_count          = 0;
      rstn                 = 1'b0;
      issue_valid          = 1'b0;
      issue_op             = 1'b0;
      issue_f              = 8'h00;
      issue_d              = 1'b1;
      issue_a              = 1'b1;
      next_two_word        = 1'b0;
      bank_select_register = 4'h0;
      ext_set_en           = 1'b0;
      index_base           = 12'h000;
      ld_en                = 1'b0;
      ld_we                = 1'b0;
      ld_addr              = 12'h000;
      ld_data              = 8'h00;
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      check({4'h0, ready, done, skip_taken, no_operation, w_out}, 16'h0800);
      t_bank_skip();
      t_low_access_w();
      t_high_access_nz();
      t_wrap_two_word();
      t_indexed_edge();
      t_ext_above();
      t_reset_mid();
      t_ext_banked();
      final_report();
   end

   // cut a hang short
   initial begin
      #(2000 * 100);
      miscompares++;
      $display("watchdog expired at %0t ns", $time);
      final_report();
   end
endmodule
